// *** design/csbu_pkg.sv ***
// Purpose: Shared constants and types of the compare, skip and branch unit
// Assumes: 8-bit status register, word-addressed program counter
// Notes:   Instruction kinds arrive already decoded from the core decoder
package csbu_pkg;

    localparam int DATA_W = 8;
    localparam int OFS_W  = 7;
    localparam int SEL_W  = 3;
    localparam int CYC_W  = 2;

    // Status register bit positions
    localparam int SR_C = 0;
    localparam int SR_Z = 1;
    localparam int SR_N = 2;
    localparam int SR_V = 3;
    localparam int SR_S = 4;
    localparam int SR_H = 5;
    localparam int SR_T = 6;
    localparam int SR_I = 7;

    localparam int MSB_BIT  = 7;
    localparam int HALF_BIT = 3;

    // Cycle counts
    localparam logic [CYC_W-1:0] CYC_ONE   = 2'h1;
    localparam logic [CYC_W-1:0] CYC_TWO   = 2'h2;
    localparam logic [CYC_W-1:0] CYC_THREE = 2'h3;

    // Program counter steps
    localparam int PC_STEP_NEXT  = 1;
    localparam int PC_STEP_SKIP1 = 2;
    localparam int PC_STEP_SKIP2 = 3;

    localparam logic [DATA_W-1:0] STATUS_REGISTER_RST = 8'h00;

    typedef enum logic [4:0] {
        op_none,
        op_cmp_skip_eq,
        op_cmp_reg,
        op_cmp_reg_with_carry,
        op_cmp_immediate,
        op_skip_reg_bit_clear,
        op_skip_reg_bit_set,
        op_skip_io_bit_clear,
        op_skip_io_bit_set,
        op_branch_status_bit_set,
        op_branch_status_bit_clear,
        op_branch_equal,
        op_branch_not_equal,
        op_branch_carry_set,
        op_branch_carry_clear,
        op_branch_same_or_higher,
        op_branch_lower,
        op_branch_minus,
        op_branch_plus,
        op_branch_signed_ge,
        op_branch_signed_lt,
        op_branch_half_carry_set,
        op_branch_half_carry_clear,
        op_branch_transfer_set,
        op_branch_transfer_clear,
        op_branch_overflow_set,
        op_branch_overflow_clear
    } csbu_op_t;

endpackage

// *** design/csbu_cmp_flags.sv ***
// Purpose: Compare subtraction and flag results, nothing written back
// Assumes: Operands stable while the request is offered
// Notes:   Purely combinational
`timescale 1ns/100ps
module csbu_cmp_flags (
    input  wire logic [csbu_pkg::DATA_W-1:0] i_lhs,
    input  wire logic [csbu_pkg::DATA_W-1:0] i_rhs,
    input  wire logic                        i_use_carry,
    input  wire logic [csbu_pkg::DATA_W-1:0] i_status_register,
    output logic      [csbu_pkg::DATA_W-1:0] o_status_register_cmp
);
    import csbu_pkg::*;

    logic [DATA_W:0]   diff;
    logic [DATA_W-1:0] res;
    logic              cin;
    logic              zero;

    always_comb begin
        cin  = i_use_carry & i_status_register[SR_C];
        diff = {1'b0, i_lhs} - {1'b0, i_rhs} - {{DATA_W{1'b0}}, cin};
        res  = diff[DATA_W-1:0];
        zero = (res == '0);
        o_status_register_cmp = i_status_register;
        // Difference only updates flags [RULE2]
        o_status_register_cmp[SR_C] = diff[DATA_W];
        o_status_register_cmp[SR_N] = res[MSB_BIT];
        o_status_register_cmp[SR_V] = (i_lhs[MSB_BIT] & ~i_rhs[MSB_BIT] & ~res[MSB_BIT])
                         | (~i_lhs[MSB_BIT] & i_rhs[MSB_BIT] & res[MSB_BIT]);
        o_status_register_cmp[SR_H] = (~i_lhs[HALF_BIT] & i_rhs[HALF_BIT])
                         | (i_rhs[HALF_BIT] & res[HALF_BIT])
                         | (res[HALF_BIT] & ~i_lhs[HALF_BIT]);
        // Carry form keeps zero only if it was already set [RULE2]
        o_status_register_cmp[SR_Z] = i_use_carry ? (zero & i_status_register[SR_Z]) : zero;
    end

endmodule

// *** design/csbu_cond.sv ***
// Purpose: Evaluates skip and branch conditions
// Assumes: Status register value is current for the instruction
// Notes:   Purely combinational
`timescale 1ns/100ps
module csbu_cond (
    input  wire csbu_pkg::csbu_op_t          i_op,
    input  wire logic [csbu_pkg::DATA_W-1:0] i_rd_val,
    input  wire logic [csbu_pkg::DATA_W-1:0] i_rr_val,
    input  wire logic [csbu_pkg::DATA_W-1:0] i_io_val,
    input  wire logic [csbu_pkg::DATA_W-1:0] i_status_register,
    input  wire logic [csbu_pkg::SEL_W-1:0]  i_bit_sel,
    output logic                             o_is_skip,
    output logic                             o_is_branch,
    output logic                             o_cond
);
    import csbu_pkg::*;

    logic rbit;
    logic iobit;
    logic sbit;
    logic n_xor_v;

    always_comb begin
        rbit    = i_rr_val[i_bit_sel];
        iobit   = i_io_val[i_bit_sel];
        sbit    = i_status_register[i_bit_sel];
        n_xor_v = i_status_register[SR_N] ^ i_status_register[SR_V];
        o_is_skip   = 1'b0;
        o_is_branch = 1'b1;
        o_cond      = 1'b0;
        case (i_op)
            op_cmp_skip_eq: begin
                o_is_skip   = 1'b1;
                o_is_branch = 1'b0;
                o_cond      = (i_rd_val == i_rr_val); // [RULE1]
            end
            op_skip_reg_bit_clear: begin
                o_is_skip   = 1'b1;
                o_is_branch = 1'b0;
                o_cond      = ~rbit; // [RULE3]
            end
            op_skip_reg_bit_set: begin
                o_is_skip   = 1'b1;
                o_is_branch = 1'b0;
                o_cond      = rbit; // [RULE4]
            end
            op_skip_io_bit_clear: begin
                o_is_skip   = 1'b1;
                o_is_branch = 1'b0;
                o_cond      = ~iobit; // [RULE5]
            end
            op_skip_io_bit_set: begin
                o_is_skip   = 1'b1;
                o_is_branch = 1'b0;
                o_cond      = iobit; // [RULE6]
            end
            op_branch_status_bit_set:   o_cond = sbit;  // [RULE8]
            op_branch_status_bit_clear: o_cond = ~sbit; // [RULE9]
            op_branch_equal:            o_cond = i_status_register[SR_Z];  // [RULE11]
            op_branch_not_equal:        o_cond = ~i_status_register[SR_Z]; // [RULE11]
            op_branch_carry_set:        o_cond = i_status_register[SR_C];  // [RULE12]
            op_branch_carry_clear:      o_cond = ~i_status_register[SR_C]; // [RULE12]
            op_branch_same_or_higher:   o_cond = ~i_status_register[SR_C]; // [RULE13]
            op_branch_lower:            o_cond = i_status_register[SR_C];  // [RULE13]
            op_branch_minus:            o_cond = i_status_register[SR_N];  // [RULE14]
            op_branch_plus:             o_cond = ~i_status_register[SR_N]; // [RULE14]
            op_branch_signed_ge:        o_cond = ~n_xor_v;      // [RULE15]
            op_branch_signed_lt:        o_cond = n_xor_v;       // [RULE15]
            op_branch_half_carry_set:   o_cond = i_status_register[SR_H];  // [RULE16]
            op_branch_half_carry_clear: o_cond = ~i_status_register[SR_H]; // [RULE16]
            op_branch_transfer_set:     o_cond = i_status_register[SR_T];  // [RULE17]
            op_branch_transfer_clear:   o_cond = ~i_status_register[SR_T]; // [RULE17]
            op_branch_overflow_set:     o_cond = i_status_register[SR_V];  // [RULE18]
            op_branch_overflow_clear:   o_cond = ~i_status_register[SR_V]; // [RULE18]
            default: begin
                o_is_branch = 1'b0;
                o_cond      = 1'b0;
            end
        endcase
    end

endmodule

// *** design/csbu_top.sv ***
// Purpose: Compare, skip and conditional branch execution for an 8-bit core
// Assumes: Decoder offers one instruction at a time with valid and ready
// Notes:   Results are registered and appear one cycle after acceptance
`timescale 1ns/100ps
// Functional notes
// RULE1 - Compare-skip-if-equal skips next instruction on equal registers, flags unchanged
// RULE2 - Compares form difference, not written back, update Z N V C H
// RULE3 - Skip next instruction when selected register bit is 0
// RULE4 - Skip next instruction when selected register bit is 1
// RULE5 - Skip next instruction when selected I/O register bit is 0
// RULE6 - Skip next instruction when selected I/O register bit is 1
// RULE7 - A skip advances the program counter by 2 or 3
// RULE8 - Generic set branch tests indexed status bit, target PC plus offset plus one
// RULE9 - Generic clear branch is taken when indexed status bit is 0
// RULE10 - Branch target PC plus offset plus one; one cycle untaken, two taken
// RULE11 - Equal and not-equal branches test zero flag
// RULE12 - Carry set and clear branches test carry flag
// RULE13 - Same-or-higher branches on carry 0, lower on carry 1
// RULE14 - Minus and plus branches test negative flag
// RULE15 - Signed branches test negative XOR overflow
// RULE16 - Half-carry branches test half-carry flag
// RULE17 - Transfer-bit branches test the transfer flag
// RULE18 - Overflow branches test the overflow flag
// RULE19 - Branch offset is signed, reach minus 64 to plus 63 words
// RULE20 - Skip costs one, two or three cycles by skipped length
module csbu_top #(
    parameter int PC_W = 16
) (
    input  wire logic                         i_clk_sys,
    input  wire logic                         i_srst,
    input  wire logic                         i_op_valid,
    output logic                              o_op_ready,
    input  wire csbu_pkg::csbu_op_t           i_op,
    input  wire logic [csbu_pkg::DATA_W-1:0]  i_rd_val,
    input  wire logic [csbu_pkg::DATA_W-1:0]  i_rr_val,
    input  wire logic [csbu_pkg::DATA_W-1:0]  i_imm,
    input  wire logic [csbu_pkg::DATA_W-1:0]  i_io_val,
    input  wire logic [csbu_pkg::SEL_W-1:0]   i_bit_sel,
    input  wire logic [csbu_pkg::OFS_W-1:0]   i_offset,
    input  wire logic [PC_W-1:0]              i_pc,
    input  wire logic                         i_next_two_word,
    input  wire logic [csbu_pkg::DATA_W-1:0]  i_status_register,
    output logic                              o_done,
    output logic                              o_pc_we,
    output logic      [PC_W-1:0]              o_pc_value,
    output logic                              o_status_register_we,
    output logic      [csbu_pkg::DATA_W-1:0]  o_status_register_value,
    output logic      [csbu_pkg::CYC_W-1:0]   o_cycles,
    output logic                              o_taken
);
    import csbu_pkg::*;

    // Refuse a program counter no wider than the signed offset
    if (PC_W < OFS_W + 1) begin : g_pc_w_check
        $error("PC_W too small for the branch offset");
    end

    typedef enum logic [1:0] {
        st_idle,
        st_stall
    } csbu_state_t;

    // Combinational decode results
    logic                is_cmp;
    logic                is_skip;
    logic                is_branch;
    logic                cond;
    logic [DATA_W-1:0]   cmp_rhs;
    logic [DATA_W-1:0]   status_register_cmp;
    logic                accept;

    // Sequencer state
    csbu_state_t         state_r;
    csbu_state_t         state_nxt;
    logic [CYC_W-1:0]    stall_r;
    logic [CYC_W-1:0]    stall_nxt;

    // Result registers
    logic                done_r;
    logic                done_nxt;
    logic                pc_we_r;
    logic                pc_we_nxt;
    logic [PC_W-1:0]     pc_val_r;
    logic [PC_W-1:0]     pc_val_nxt;
    logic                status_register_we_r;
    logic                status_register_we_nxt;
    logic [DATA_W-1:0]   status_register_val_r;
    logic [DATA_W-1:0]   status_register_val_nxt;
    logic [CYC_W-1:0]    cycles_r;
    logic [CYC_W-1:0]    cycles_nxt;
    logic                taken_r;
    logic                taken_nxt;

    // Sign extend the word offset to program counter width
    function automatic logic [PC_W-1:0] sext_ofs(input logic [OFS_W-1:0] ofs);
        sext_ofs = {{(PC_W-OFS_W){ofs[OFS_W-1]}}, ofs};
    endfunction

    // Program counter plus a small step
    function automatic logic [PC_W-1:0] pc_plus(input logic [PC_W-1:0] pc,
                                                input int              step);
        pc_plus = pc + PC_W'(step);
    endfunction

    csbu_cmp_flags u_cmp (
        .i_lhs       (i_rd_val),
        .i_rhs       (cmp_rhs),
        .i_use_carry (i_op == op_cmp_reg_with_carry),
        .i_status_register      (i_status_register),
        .o_status_register_cmp  (status_register_cmp)
    );

    csbu_cond u_cond (
        .i_op        (i_op),
        .i_rd_val    (i_rd_val),
        .i_rr_val    (i_rr_val),
        .i_io_val    (i_io_val),
        .i_status_register      (i_status_register),
        .i_bit_sel   (i_bit_sel),
        .o_is_skip   (is_skip),
        .o_is_branch (is_branch),
        .o_cond      (cond)
    );

    always_comb begin
        is_cmp  = (i_op == op_cmp_reg) || (i_op == op_cmp_reg_with_carry)
                || (i_op == op_cmp_immediate);
        cmp_rhs = (i_op == op_cmp_immediate) ? i_imm : i_rr_val; // [RULE2]
        accept  = i_op_valid && (state_r == st_idle);
        o_op_ready = (state_r == st_idle);
    end

    // Next state and results
    always_comb begin
        state_nxt    = state_r;
        stall_nxt    = stall_r;
        done_nxt     = 1'b0;
        pc_we_nxt    = 1'b0;
        pc_val_nxt   = pc_val_r;
        status_register_we_nxt  = 1'b0;
        status_register_val_nxt = status_register_val_r;
        cycles_nxt   = cycles_r;
        taken_nxt    = 1'b0;
        case (state_r)
            st_idle: begin
                if (accept) begin
                    done_nxt   = 1'b1;
                    pc_we_nxt  = 1'b1;
                    pc_val_nxt = pc_plus(i_pc, PC_STEP_NEXT);
                    cycles_nxt = CYC_ONE;
                    if (is_cmp) begin
                        status_register_we_nxt  = 1'b1; // [RULE2]
                        status_register_val_nxt = status_register_cmp;
                    end else if (is_skip && cond) begin
                        taken_nxt = 1'b1;
                        if (i_next_two_word) begin
                            pc_val_nxt = pc_plus(i_pc, PC_STEP_SKIP2); // [RULE7]
                            cycles_nxt = CYC_THREE; // [RULE20]
                        end else begin
                            pc_val_nxt = pc_plus(i_pc, PC_STEP_SKIP1); // [RULE7]
                            cycles_nxt = CYC_TWO; // [RULE20]
                        end
                    end else if (is_branch && cond) begin
                        taken_nxt  = 1'b1;
                        // Signed offset from the next instruction [RULE19] [RULE10]
                        pc_val_nxt = pc_plus(i_pc, PC_STEP_NEXT) + sext_ofs(i_offset);
                        cycles_nxt = CYC_TWO; // [RULE10]
                    end
                    if (cycles_nxt != CYC_ONE) begin
                        state_nxt = st_stall;
                        stall_nxt = cycles_nxt - CYC_ONE;
                    end
                end
            end
            st_stall: begin
                // Hold off the decoder for the extra cycles [RULE20] [RULE10]
                stall_nxt = stall_r - CYC_ONE;
                if (stall_r == CYC_ONE) begin
                    state_nxt = st_idle;
                end
            end
            default: begin
                state_nxt = st_idle;
                stall_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            state_r    <= st_idle;
            stall_r    <= '0;
            done_r     <= 1'b0;
            pc_we_r    <= 1'b0;
            pc_val_r   <= '0;
            status_register_we_r  <= 1'b0;
            status_register_val_r <= STATUS_REGISTER_RST;
            cycles_r   <= '0;
            taken_r    <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            stall_r    <= stall_nxt;
            done_r     <= done_nxt;
            pc_we_r    <= pc_we_nxt;
            pc_val_r   <= pc_val_nxt;
            status_register_we_r  <= status_register_we_nxt;
            status_register_val_r <= status_register_val_nxt;
            cycles_r   <= cycles_nxt;
            taken_r    <= taken_nxt;
        end
    end

    always_comb begin
        o_done       = done_r;
        o_pc_we      = pc_we_r;
        o_pc_value   = pc_val_r;
        o_status_register_we    = status_register_we_r;
        o_status_register_value = status_register_val_r;
        o_cycles     = cycles_r;
        o_taken      = taken_r;
    end

endmodule

// *** verification/csbu_checker_assertions.sv ***
// Purpose: Concurrent checks on the ports of csbu_top
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound into every csbu_top instance
`timescale 1ns/100ps
module csbu_checker #(
    parameter int PC_W = 16
) (
    input  wire logic                        i_clk_sys,
    input  wire logic                        i_srst,
    input  wire logic                        i_op_valid,
    input  wire logic                        o_op_ready,
    input  wire csbu_pkg::csbu_op_t          i_op,
    input  wire logic [csbu_pkg::DATA_W-1:0] i_rd_val,
    input  wire logic [csbu_pkg::DATA_W-1:0] i_rr_val,
    input  wire logic [csbu_pkg::OFS_W-1:0]  i_offset,
    input  wire logic [PC_W-1:0]             i_pc,
    input  wire logic                        o_done,
    input  wire logic                        o_pc_we,
    input  wire logic [PC_W-1:0]             o_pc_value,
    input  wire logic                        o_status_register_we,
    input  wire logic [csbu_pkg::DATA_W-1:0] o_status_register_value,
    input  wire logic [csbu_pkg::CYC_W-1:0]  o_cycles,
    input  wire logic                        o_taken
);
    import csbu_pkg::*;
    logic take;
    assign take = i_op_valid && o_op_ready;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_srst);

    a_done_after_take: assert property (take |=> o_done && o_pc_we)
        else $error("no result one cycle after accept");
    a_done_has_cause: assert property (o_done |-> $past(take))
        else $error("result without accepted instruction");
    a_pulses_with_done: assert property ((o_pc_we || o_status_register_we || o_taken) |-> o_done)
        else $error("strobe outside result cycle");
    a_ready_after_one: assert property (o_done && o_cycles == CYC_ONE |-> o_op_ready)
        else $error("busy after single cycle instruction");
    a_busy_after_two: assert property (o_done && o_cycles == CYC_TWO |->
        !o_op_ready ##1 o_op_ready) else $error("wrong busy time for two cycles");
    a_busy_after_three: assert property (o_done && o_cycles == CYC_THREE |->
        !o_op_ready [*2] ##1 o_op_ready) else $error("wrong busy time for three cycles");
    a_untaken_next_pc: assert property (o_done && !o_taken |->
        o_pc_value == $past(i_pc) + PC_W'(1) && o_cycles == CYC_ONE)
        else $error("untaken result wrong");
    a_skip_pc_step: assert property (o_done && o_taken && $past(i_op) <= op_skip_io_bit_set |->
        o_cycles != CYC_ONE && o_pc_value == $past(i_pc) + PC_W'(o_cycles))
        else $error("skip step wrong");
    a_branch_target: assert property (o_done && o_taken && $past(i_op) >= op_branch_status_bit_set |->
        o_cycles == CYC_TWO &&
        o_pc_value == $past(i_pc) + PC_W'(1) + PC_W'($signed($past(i_offset))))
        else $error("branch target wrong");
    a_flags_cmp_only: assert property (o_done |-> o_status_register_we ==
        ($past(i_op) inside {op_cmp_reg, op_cmp_reg_with_carry, op_cmp_immediate}))
        else $error("status write on wrong instruction");
    a_cmp_zero_flag: assert property (o_status_register_we && $past(i_op) == op_cmp_reg |->
        o_status_register_value[SR_Z] == ($past(i_rd_val) == $past(i_rr_val)))
        else $error("zero flag wrong after compare");
endmodule
bind csbu_top csbu_checker #(.PC_W(PC_W)) u_csbu_checker (
    .i_clk_sys, .i_srst, .i_op_valid, .o_op_ready, .i_op, .i_rd_val, .i_rr_val, .i_offset,
    .i_pc, .o_done, .o_pc_we, .o_pc_value, .o_status_register_we, .o_status_register_value, .o_cycles, .o_taken
);

// *** verification/tb_compare_skip_branch_unit.sv ***
// Purpose: Self-checking bench of csbu_top
// Assumes: Results compared in order of acceptance
// Notes:   Directed corners, every kind with status and I/O bits all 0 then all 1, then random traffic
`timescale 1ns/100ps
module tb_compare_skip_branch_unit;
    import csbu_pkg::*;
    typedef struct packed {
        logic              tk;
        logic [CYC_W-1:0]  cyc;
        logic [15:0]       pc;
        logic              swe;
        logic [DATA_W-1:0] sr;
    } csbu_exp_t;
    logic i_clk_sys, i_srst, i_op_valid, i_next_two_word;
    csbu_op_t i_op;
    logic [DATA_W-1:0] i_rd_val, i_rr_val, i_imm;
    logic [DATA_W-1:0] i_io_val, i_status_register, o_status_register_value, sr_hold;
    logic [SEL_W-1:0]  i_bit_sel;
    logic [OFS_W-1:0]  i_offset;
    logic [15:0]       i_pc, o_pc_value;
    logic [CYC_W-1:0]  o_cycles;
    logic              o_op_ready, o_done, o_pc_we, o_status_register_we, o_taken;
    logic              rdy_n = 1'b1;
    int                err_total = 0, n_tests = 0;
    csbu_exp_t         exp_q[$];
    csbu_exp_t         e;

    csbu_top #(.PC_W(16)) dut (.i_clk_sys, .i_srst, .i_op_valid, .o_op_ready, .i_op,
        .i_rd_val, .i_rr_val, .i_imm, .i_io_val, .i_bit_sel, .i_offset, .i_pc,
        .i_next_two_word, .i_status_register, .o_done, .o_pc_we, .o_pc_value, .o_status_register_we,
        .o_status_register_value, .o_cycles, .o_taken);

    always #2 i_clk_sys = ~i_clk_sys;

    task automatic print_verdict();
        if (err_total == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk_bit(input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic chk_val(input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    function automatic csbu_exp_t model(input csbu_op_t o, input logic [7:0] a, b, k8, p, s,
                                        input logic [2:0] bs, input logic [6:0] k,
                                        input logic [15:0] c, input logic w);
        csbu_exp_t r;
        logic [8:0] d;
        logic [4:0] h;
        logic [7:0] y;
        logic       ci, hit;
        r = '{tk: 1'b0, cyc: CYC_ONE, pc: c + 16'h0001, swe: 1'b0, sr: s};
        ci = (o == op_cmp_reg_with_carry) & s[SR_C];
        y = (o == op_cmp_immediate) ? k8 : b;
        d = {1'b0, a} - {1'b0, y} - {8'h00, ci};
        h = {1'b0, a[3:0]} - {1'b0, y[3:0]} - {4'h0, ci};
        hit = 1'b0;
        case (o)
            op_cmp_skip_eq: hit = (a == b);
            op_skip_reg_bit_clear: hit = !b[bs];
            op_skip_reg_bit_set: hit = b[bs];
            op_skip_io_bit_clear: hit = !p[bs];
            op_skip_io_bit_set: hit = p[bs];
            op_branch_status_bit_set: hit = s[bs];
            op_branch_status_bit_clear: hit = !s[bs];
            op_branch_equal: hit = s[SR_Z];
            op_branch_not_equal: hit = !s[SR_Z];
            op_branch_carry_set, op_branch_lower: hit = s[SR_C];
            op_branch_carry_clear, op_branch_same_or_higher: hit = !s[SR_C];
            op_branch_minus: hit = s[SR_N];
            op_branch_plus: hit = !s[SR_N];
            op_branch_signed_ge: hit = !(s[SR_N] ^ s[SR_V]);
            op_branch_signed_lt: hit = s[SR_N] ^ s[SR_V];
            op_branch_half_carry_set: hit = s[SR_H];
            op_branch_half_carry_clear: hit = !s[SR_H];
            op_branch_transfer_set: hit = s[SR_T];
            op_branch_transfer_clear: hit = !s[SR_T];
            op_branch_overflow_set: hit = s[SR_V];
            op_branch_overflow_clear: hit = !s[SR_V];
            op_cmp_reg, op_cmp_reg_with_carry, op_cmp_immediate: begin
                r.swe = 1'b1;
                r.sr[SR_C] = d[8];
                r.sr[SR_H] = h[4];
                r.sr[SR_N] = d[7];
                r.sr[SR_V] = (a[7] != y[7]) && (d[7] != a[7]);
                r.sr[SR_Z] = (d[7:0] == 8'h00) && (o != op_cmp_reg_with_carry || s[SR_Z]);
            end
            default: hit = 1'b0;
        endcase
        if (hit && o <= op_skip_io_bit_set) begin
            r.tk = 1'b1;
            r.cyc = w ? CYC_THREE : CYC_TWO;
            r.pc = c + (w ? 16'h0003 : 16'h0002);
        end
        if (hit && o >= op_branch_status_bit_set) begin
            r.tk = 1'b1;
            r.cyc = CYC_TWO;
            r.pc = c + 16'h0001 + {{9{k[6]}}, k};
        end
        return r;
    endfunction

    // Offers one instruction and holds it until accepted
    task automatic send(input csbu_op_t o, input logic [7:0] a = 8'h00, b = 8'h00,
                        k8 = 8'h00, p = 8'h00, s = 8'h00, input logic [2:0] bs = 3'h0,
                        input logic [6:0] k = 7'h00, input logic [15:0] c = 16'h0100,
                        input logic w = 1'b0);
        int n;
        n = 0;
        i_op_valid <= 1'b1;
        i_op <= o;
        i_rd_val <= a;
        i_rr_val <= b;
        i_imm <= k8;
        i_io_val <= p;
        i_status_register <= s;
        i_bit_sel <= bs;
        i_offset <= k;
        i_pc <= c;
        i_next_two_word <= w;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (rdy_n !== 1'b1 && n < 8);
        if (n >= 8) begin
            err_total++;
            print_verdict();
        end
        exp_q.push_back(model(o, a, b, k8, p, s, bs, k, c, w));
    endtask

    task automatic idle(input int n);
        i_op_valid <= 1'b0;
        repeat (n) @(posedge i_clk_sys);
    endtask

    task automatic rst_chk();
        @(negedge i_clk_sys);
        chk_bit(1'b1, o_op_ready);
        chk_bit(1'b0, o_done);
        chk_val(16'h0000, o_pc_value);
        chk_val(16'h0000, {8'h00, o_status_register_value});
        chk_val(16'h0000, {14'h0000, o_cycles});
        @(posedge i_clk_sys);
    endtask

    always @(negedge i_clk_sys) begin
        rdy_n = o_op_ready;
        if (i_srst === 1'b1) begin
            sr_hold = STATUS_REGISTER_RST;
        end
        if (!i_srst && o_done === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk_bit(1'b0, o_done);
            end else begin
                e = exp_q.pop_front();
                chk_bit(e.tk, o_taken);
                chk_val({14'h0000, e.cyc}, {14'h0000, o_cycles});
                chk_val(e.pc, o_pc_value);
                chk_bit(1'b1, o_pc_we);
                chk_bit(e.swe, o_status_register_we);
                // Status output holds its last compare result otherwise
                if (e.swe) begin
                    sr_hold = e.sr;
                end
                chk_val({8'h00, sr_hold}, {8'h00, o_status_register_value});
            end
        end
    end

    initial begin
        int         i;
        logic [7:0] f;
        i_clk_sys = 1'b0;
        i_srst <= 1'b1;
        i_op_valid <= 1'b0;
        i_next_two_word <= 1'b0;
        i_op <= op_none;
        i_rd_val <= 8'h00;
        i_rr_val <= 8'h00;
        i_imm <= 8'h00;
        i_io_val <= 8'h00;
        i_status_register <= 8'h00;
        i_bit_sel <= 3'h0;
        i_offset <= 7'h00;
        i_pc <= 16'h0000;
        void'($urandom(32'hDB8D8E61));
        repeat (20) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        rst_chk();
        send(.o(op_cmp_reg), .a(8'h80), .b(8'h01));
        send(.o(op_cmp_reg_with_carry), .a(8'h01), .s(8'h01));
        send(.o(op_cmp_reg_with_carry), .a(8'h01), .s(8'h03));
        send(.o(op_cmp_immediate), .k8(8'h01), .s(8'hFF));
        send(.o(op_cmp_skip_eq), .a(8'h33), .b(8'h33), .c(16'hFFFE), .w(1'b1));
        send(.o(op_skip_io_bit_set), .p(8'h80), .bs(3'h7), .w(1'b1));
        send(.o(op_branch_equal), .s(8'h02), .k(7'h40), .c(16'h0000));
        send(.o(op_branch_not_equal), .k(7'h3F), .c(16'hFFFF));
        for (i = 0; i < 54; i++) begin
            f = (i < 27) ? 8'h00 : 8'hFF;
            send(csbu_op_t'(i % 27), 8'h5A, 8'h5A, 8'hA5, f, f, 3'(i),
                 (i < 27) ? 7'h40 : 7'h3F, 16'(i * 977), i[0]);
        end
        for (i = 0; i < 500; i++) begin
            send(csbu_op_t'($urandom_range(26)), 8'($urandom), 8'($urandom),
                 8'($urandom), 8'($urandom), 8'($urandom), 3'($urandom),
                 7'($urandom), 16'($urandom), 1'($urandom));
            if ($urandom_range(3) == 0) idle(1 + $urandom_range(2));
        end
        send(.o(op_cmp_skip_eq), .a(8'h11), .b(8'h11), .w(1'b1));
        i_op_valid <= 1'b0;
        i_srst <= 1'b1;
        exp_q.delete();
        repeat (3) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        rst_chk();
        send(.o(op_branch_minus), .s(8'h04), .k(7'h05));
        idle(5);
        chk_val(16'h0000, 16'(exp_q.size()));
        print_verdict();
    end
endmodule
